// >>> inc/dpc_defs.svh
// Constants for the dual pulse counter.
// Operation
// - Single reference 16 bits, joined reference 32.
// - Start may add one spurious count; here a start adds none.
// - Stop freezes count until restart or clear.
// - Status bit 22 counter zero, 23 counter one.
// - Joined counter status reported in bit 22.
// - Status read clears returned set flags.
// - Enabled interrupt fires when reference passed.
// - Single count read does not disturb counter.
// - Single read path never gives joined count.
// - Joined read gives count and joined indication.
// - Single clear zeroes only that 16-bit count.
// - Joined clear acts only while joined.
// - Edge select: 0 rising, 1 falling.
// - Debounce codes need 1, 2, 4, 8 samples.
// - Join field: off, first input, second input.
// - Passed at reference plus one; wraps at maximum.
`ifndef DPC_DEFS_SVH
`define DPC_DEFS_SVH
`define DPC_STAT_BIT0 22
`define DPC_STAT_BIT1 23
`define DPC_JOIN_OFF 2'h0
`define DPC_JOIN_FIRST 2'h1
`define DPC_JOIN_SECOND 2'h2
`define DPC_CNT_RESET 16'h0000
`define DPC_REF_RESET 16'h0000
// Extra matching samples wanted for each debounce code.
`define DPC_DEB_NEED0 3'h0
`define DPC_DEB_NEED1 3'h1
`define DPC_DEB_NEED2 3'h3
`define DPC_DEB_NEED3 3'h7
`endif

// >>> inc/dpc_pkg.sv
// Types shared by the dual pulse counter files.
package dpc_pkg;
    // Per-counter configuration.
    typedef struct packed {
        logic       falling;
        logic [1:0] debounce;
        logic       irq_en;
    } dpc_cfg_t;
    // Debounce filter state.
    typedef enum logic [1:0] {
        DPC_IDLE = 2'b01,
        DPC_RUN  = 2'b10
    } dpc_fsm_t;
    typedef struct packed {
        dpc_fsm_t   fsm;
        logic       level;
        logic [2:0] same;
        logic       edge_seen;
    } dpc_flt_t;
endpackage

// >>> core/dpc_filter.sv
// Input debounce and edge qualifier for one pulse input.
`timescale 1ns/1ps
`include "dpc_defs.svh"
module dpc_filter (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic pin,
    input wire dpc_pkg::dpc_cfg_t cfg,
    output logic edge_seen
);
    dpc_pkg::dpc_flt_t r;
    dpc_pkg::dpc_flt_t next_r;

    // Number of extra matching samples needed for each debounce code.
    function automatic logic [2:0] need(input logic [1:0] code);
        case (code)
            2'h0: need = `DPC_DEB_NEED0;
            2'h1: need = `DPC_DEB_NEED1;
            2'h2: need = `DPC_DEB_NEED2;
            default: need = `DPC_DEB_NEED3;
        endcase
    endfunction

    // Accept a new level once enough identical samples were seen.
    always_comb
    begin
        next_r = r;
        next_r.edge_seen = 1'b0;
        case (r.fsm)
            dpc_pkg::DPC_IDLE:
            begin
                next_r.level = pin;
                next_r.fsm = dpc_pkg::DPC_RUN;
            end
            dpc_pkg::DPC_RUN:
            begin
                if (pin == r.level)
                begin
                    next_r.same = 3'h0;
                end
                else if (r.same >= need(cfg.debounce))
                begin
                    next_r.level = pin;
                    next_r.same = 3'h0;
                    next_r.edge_seen = (pin != cfg.falling);
                end
                else
                begin
                    next_r.same = r.same + 3'h1;
                end
            end
            default: next_r.fsm = dpc_pkg::DPC_IDLE;
        endcase
    end

    // State register with clock enable.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '{fsm: dpc_pkg::DPC_IDLE, level: 1'b0, same: 3'h0, edge_seen: 1'b0};
        end
        else if (clk_en)
        begin
            r <= next_r;
        end
    end

    assign edge_seen = r.edge_seen;
endmodule

// >>> core/dpc_top.sv
// Dual 16-bit pulse counter, joinable into one 32-bit counter.
`timescale 1ns/1ps
`include "dpc_defs.svh"
module dpc_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic pin0,
    input wire logic pin1,
    input wire dpc_pkg::dpc_cfg_t cfg0,
    input wire dpc_pkg::dpc_cfg_t cfg1,
    input wire logic [1:0] join_mode,
    input wire logic start0,
    input wire logic start1,
    input wire logic stop0,
    input wire logic stop1,
    input wire logic clear16_0,
    input wire logic clear16_1,
    input wire logic clear32,
    input wire logic ref_wr0,
    input wire logic ref_wr1,
    input wire logic [31:0] ref_data,
    input wire logic status_rd,
    output logic ref_ok,
    output logic [31:0] status,
    output logic [15:0] count16_0,
    output logic [15:0] count16_1,
    output logic [31:0] count32,
    output logic joined,
    output logic irq
);
    typedef struct packed {
        logic        rs1;
        logic        rs2;
    } dpc_rst_t;

    typedef struct packed {
        logic [1:0]  run;
        logic [31:0] cnt;
        logic [31:0] refv;
        logic [1:0]  flag;
        logic        ref_ok;
        logic [31:0] status;
        logic [15:0] count16_0;
        logic [15:0] count16_1;
        logic [31:0] count32;
        logic        joined;
        logic        irq;
    } dpc_state_t;

    dpc_rst_t rs;
    dpc_state_t r;
    dpc_state_t next_r;
    logic srst_n;
    logic edge0;
    logic edge1;
    logic is_join;
    logic [15:0] inc0;
    logic [15:0] inc1;
    logic [31:0] inc32;

    // Two-stage release of the asynchronous reset.
    // The chain ignores the clock enable, so a reset always runs to its end.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rs <= '0;
        end
        else
        begin
            rs <= '{rs1: 1'b1, rs2: rs.rs1};
        end
    end
    assign srst_n = rs.rs2;

    // Joined counter takes counter zero settings on the selected input.
    dpc_filter u_flt0 (
        .sys_clk(sys_clk),
        .rst_n(srst_n),
        .clk_en(clk_en),
        .pin((join_mode == `DPC_JOIN_SECOND) ? pin1 : pin0),
        .cfg(cfg0),
        .edge_seen(edge0)
    );
    dpc_filter u_flt1 (
        .sys_clk(sys_clk),
        .rst_n(srst_n),
        .clk_en(clk_en),
        .pin(pin1),
        .cfg(cfg1),
        .edge_seen(edge1)
    );

    // Mode three is treated as separate counters.
    assign is_join = (join_mode == `DPC_JOIN_FIRST) || (join_mode == `DPC_JOIN_SECOND);
    assign inc0 = r.cnt[15:0] + 16'h0001;
    assign inc1 = r.cnt[31:16] + 16'h0001;
    assign inc32 = r.cnt + 32'h0000_0001;

    // A reference is passed when the fresh count equals reference plus one.
    function automatic logic passed16(input logic [15:0] cnt_now, input logic [15:0] ref_now);
        passed16 = (cnt_now == ref_now + 16'h0001);
    endfunction

    // The same test for the joined 32-bit counter.
    function automatic logic passed32(input logic [31:0] cnt_now, input logic [31:0] ref_now);
        passed32 = (cnt_now == ref_now + 32'h0000_0001);
    endfunction

    // Counting, reference compare, flags and read-back.
    always_comb
    begin
        next_r = r;
        next_r.irq = 1'b0;
        next_r.ref_ok = 1'b0;
        // A status read clears the flags first, so an event in the same cycle sets them again.
        if (status_rd)
            next_r.flag = 2'h0;
        // Start and stop; a start does not count by itself here.
        if (start0)
            next_r.run[0] = 1'b1;
        if (start1)
            next_r.run[1] = 1'b1;
        if (stop0)
            next_r.run[0] = 1'b0;
        if (stop1)
            next_r.run[1] = 1'b0;
        // Count only qualified edges while running, wrapping at the top.
        if (is_join)
        begin
            if (r.run[0] && edge0)
            begin
                next_r.cnt = inc32;
                if (passed32(inc32, r.refv))
                begin
                    next_r.flag[0] = 1'b1;
                    next_r.irq = cfg0.irq_en;
                end
            end
            if (clear32)
                next_r.cnt = 32'h0000_0000;
        end
        else
        begin
            if (r.run[0] && edge0)
            begin
                next_r.cnt[15:0] = inc0;
                if (passed16(inc0, r.refv[15:0]))
                begin
                    next_r.flag[0] = 1'b1;
                    next_r.irq = cfg0.irq_en;
                end
            end
            if (r.run[1] && edge1)
            begin
                next_r.cnt[31:16] = inc1;
                if (passed16(inc1, r.refv[31:16]))
                begin
                    next_r.flag[1] = 1'b1;
                    next_r.irq = next_r.irq | cfg1.irq_en;
                end
            end
            if (clear16_0)
                next_r.cnt[15:0] = `DPC_CNT_RESET;
            if (clear16_1)
                next_r.cnt[31:16] = `DPC_CNT_RESET;
        end
        // Reference writes; singles reject values wider than 16 bits.
        if (ref_wr0)
        begin
            if (is_join)
            begin
                next_r.refv = ref_data;
                next_r.ref_ok = 1'b1;
            end
            else if (ref_data[31:16] == 16'h0000)
            begin
                next_r.refv[15:0] = ref_data[15:0];
                next_r.ref_ok = 1'b1;
            end
        end
        // Counter one takes only a narrow reference, and never while joined.
        if (ref_wr1 && !is_join && (ref_data[31:16] == 16'h0000))
        begin
            next_r.refv[31:16] = ref_data[15:0];
            next_r.ref_ok = 1'b1;
        end
        // Status snapshot of the flags as they stood before this read.
        if (status_rd)
        begin
            next_r.status = 32'h0000_0000;
            next_r.status[`DPC_STAT_BIT0] = r.flag[0];
            next_r.status[`DPC_STAT_BIT1] = r.flag[1] & ~is_join;
        end
        // Live count views that leave the counters untouched.
        next_r.count16_0 = is_join ? 16'h0000 : next_r.cnt[15:0];
        next_r.count16_1 = is_join ? 16'h0000 : next_r.cnt[31:16];
        next_r.count32 = is_join ? next_r.cnt : 32'h0000_0000;
        next_r.joined = is_join;
    end

    // State register; reset stops and zeroes everything.
    always_ff @(posedge sys_clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            r <= '0;
        end
        else if (clk_en)
        begin
            r <= next_r;
        end
    end

    assign ref_ok = r.ref_ok;
    assign status = r.status;
    assign count16_0 = r.count16_0;
    assign count16_1 = r.count16_1;
    assign count32 = r.count32;
    assign joined = r.joined;
    assign irq = r.irq;
endmodule

// >>> tb/dpc_chk.sv
// Port checks for the dual pulse counter.
`timescale 1ns/1ps
module dpc_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start0,
    input wire logic stop0,
    input wire logic clear16_0,
    input wire logic clear32,
    input wire logic ref_wr0,
    input wire logic ref_wr1,
    input wire logic [31:0] ref_data,
    input wire logic [1:0] join_mode,
    input wire logic ref_ok,
    input wire logic [31:0] status,
    input wire logic [15:0] count16_0,
    input wire logic [31:0] count32,
    input wire logic joined
);
    // All checks use the system clock and rest during reset.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // A stop with no restart or clear after it leaves the count still.
    sequence s_halt;
        stop0 && !joined ##1 (!start0 && !clear16_0 && !joined) [*4];
    endsequence
    property p_stop_hold;
        s_halt |-> $stable(count16_0);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("count moved");
    property p_ref_bad;
        ref_wr0 && !ref_wr1 && join_mode == 2'h0 && ref_data[31:16] != 16'h0000 |=> !ref_ok;
    endproperty
    a_ref_bad: assert property (p_ref_bad) else $error("wide ref taken");
    property p_ref_good;
        ref_wr0 && ref_data[31:16] == 16'h0000 |=> ref_ok;
    endproperty
    a_ref_good: assert property (p_ref_good) else $error("ref refused");
    property p_stat_clean;
        status[31:24] == 8'h00 && status[21:0] == 22'h00_0000;
    endproperty
    a_stat_clean: assert property (p_stat_clean) else $error("stray status");
    property p_single32;
        !joined && !$past(joined) |-> count32 == 32'h0000_0000;
    endproperty
    a_single32: assert property (p_single32) else $error("count32 unjoined");
    property p_joined16;
        joined && $past(joined) |-> count16_0 == 16'h0000;
    endproperty
    a_joined16: assert property (p_joined16) else $error("count16 joined");
    property p_clear32;
        clear32 && joined && join_mode != 2'h0 |-> ##[1:2] count32 == 32'h0000_0000;
    endproperty
    a_clear32: assert property (p_clear32) else $error("clear32 lost");
    property p_join_up;
        join_mode == 2'h1 && $past(join_mode) == 2'h1 |=> joined;
    endproperty
    a_join_up: assert property (p_join_up) else $error("not joined");
endmodule

// >>> tb/dpc_src.sv
// Pulse source model for one counter input.
`timescale 1ns/1ps
module dpc_src (
    input wire logic sys_clk,
    output logic pin
);
    initial pin = 1'b0;
    // Holds high then low for whole cycles; short spans make glitches.
    // Each level is set one step after a rising edge, like every other bench input.
    task automatic pulse(input int hi, input int lo);
        repeat (hi)
        begin
            pin = 1'b1;
            @(posedge sys_clk);
            #1;
        end
        repeat (lo)
        begin
            pin = 1'b0;
            @(posedge sys_clk);
            #1;
        end
    endtask
endmodule

// >>> tb/dpc_tb_top.sv
// Self-checking bench for the dual pulse counter.
`timescale 1ns/1ps
`include "dpc_defs.svh"
module dpc_tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, pin0, pin1, status_rd = 1'b0, stop1 = 1'b0;
    logic start0 = 1'b0, start1 = 1'b0, stop0 = 1'b0, clear32 = 1'b0, clear16_0 = 1'b0, clear16_1 = 1'b0;
    logic ref_wr0 = 1'b0, ref_wr1 = 1'b0, ref_ok, joined, irq;
    logic [1:0] join_mode = 2'h0;
    logic [31:0] ref_data = 32'h0000_0000, status, count32;
    logic [15:0] count16_0, count16_1;
    dpc_pkg::dpc_cfg_t cfg0 = '0, cfg1 = '0;
    int bad_count = 0, samples_checked = 0, irq_seen = 0;
    always #5 sys_clk = ~sys_clk;
    // Counts interrupt pulses mid-cycle, where each stands for one whole cycle.
    always @(negedge sys_clk) if (irq === 1'b1) irq_seen++;
    dpc_top i_dpc_top (.sys_clk, .rst_n, .clk_en, .pin0, .pin1, .cfg0, .cfg1, .join_mode, .start0, .start1,
        .stop0, .stop1, .clear16_0, .clear16_1, .clear32, .ref_wr0, .ref_wr1, .ref_data, .status_rd,
        .ref_ok, .status, .count16_0, .count16_1, .count32, .joined, .irq);
    dpc_src i_dpc_src_0 (.sys_clk, .pin(pin0));
    dpc_src i_dpc_src_1 (.sys_clk, .pin(pin1));
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Pulses a strobe for one edge, then lets one edge pass before the next call.
    task automatic hit(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask
    task automatic put_ref(input logic one, input logic [31:0] d, input logic ok);
        ref_data = d;
        ref_wr0 = !one;
        ref_wr1 = one;
        tick(1);
        check({31'h0, ref_ok}, {31'h0, ok});
        ref_wr0 = 1'b0;
        ref_wr1 = 1'b0;
        tick(1);
    endtask
    task automatic read_status(input logic [31:0] exp);
        hit(status_rd);
        check(status, exp);
    endtask
    // Cuts a hung run short.
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        bad_count++;
        close_out();
    end
    // Main sequence.
    initial
    begin
        tick(5);
        rst_n = 1'b1;
        tick(4);
        check({count16_0, count16_1}, 32'h0000_0000);
        read_status(32'h0000_0000);
        put_ref(1'b0, 32'h0001_0002, 1'b0);
        put_ref(1'b0, 32'h0000_0002, 1'b1);
        cfg0 = '{1'b0, 2'h0, 1'b1};
        hit(start0);
        repeat (3) i_dpc_src_0.pulse(2, 10);
        check({16'h0, count16_0}, 32'h0000_0003);
        check(irq_seen, 1);
        read_status(32'h0040_0000);
        read_status(32'h0000_0000);
        // A low clock enable freezes the filter and the count.
        clk_en = 1'b0;
        i_dpc_src_0.pulse(2, 10);
        clk_en = 1'b1;
        check({16'h0, count16_0}, 32'h0000_0003);
        hit(stop0);
        i_dpc_src_0.pulse(2, 10);
        check({16'h0, count16_0}, 32'h0000_0003);
        hit(clear16_0);
        tick(2);
        check({16'h0, count16_0}, 32'h0000_0000);
        cfg1 = '{1'b1, 2'h3, 1'b0};
        put_ref(1'b1, 32'h0000_0001, 1'b1);
        hit(start1);
        i_dpc_src_1.pulse(12, 3);
        i_dpc_src_1.pulse(12, 0);
        check({16'h0, count16_1}, 32'h0000_0000);
        i_dpc_src_1.pulse(0, 16);
        check({16'h0, count16_1}, 32'h0000_0001);
        i_dpc_src_1.pulse(12, 16);
        read_status(32'h0080_0000);
        check(irq_seen, 1);
        // Shorter debounce codes reject a short low and take a long one.
        cfg1 = '{1'b1, 2'h1, 1'b0};
        i_dpc_src_1.pulse(4, 1);
        i_dpc_src_1.pulse(4, 4);
        check({16'h0, count16_1}, 32'h0000_0003);
        cfg1 = '{1'b1, 2'h2, 1'b0};
        i_dpc_src_1.pulse(4, 3);
        i_dpc_src_1.pulse(4, 6);
        check({16'h0, count16_1}, 32'h0000_0004);
        join_mode = `DPC_JOIN_FIRST;
        tick(2);
        hit(clear32);
        put_ref(1'b0, 32'h0001_0000, 1'b1);
        put_ref(1'b0, 32'h0000_0001, 1'b1);
        hit(start0);
        check({31'h0, joined}, 32'h0000_0001);
        repeat (2) i_dpc_src_0.pulse(2, 10);
        check(irq_seen, 2);
        hit(clear16_0);
        tick(2);
        check(count32, 32'h0000_0002);
        read_status(32'h0040_0000);
        hit(clear32);
        tick(2);
        check(count32, 32'h0000_0000);
        join_mode = `DPC_JOIN_SECOND;
        tick(2);
        i_dpc_src_0.pulse(2, 10);
        i_dpc_src_1.pulse(2, 10);
        check(count32, 32'h0000_0001);
        join_mode = `DPC_JOIN_OFF;
        tick(2);
        hit(clear32);
        tick(2);
        check({15'h0, joined, count16_0}, 32'h0000_0001);
        // A reset in mid-run zeroes the counts and the status snapshot.
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(4);
        check({15'h0, joined, count16_0}, 32'h0000_0000);
        check(status, 32'h0000_0000);
        close_out();
    end
endmodule
bind dpc_top dpc_chk i_dpc_chk (.sys_clk, .rst_n, .start0, .stop0, .clear16_0, .clear32, .ref_wr0, .ref_wr1,
    .ref_data, .join_mode, .ref_ok, .status, .count16_0, .count32, .joined);
